// ---- rtc_map.svh ----
// Purpose: Offsets, field positions, codes and timing figures of the seconds clock
// Assumes: 50 MHz system clock, 32.768 kHz oscillator on a pin
// Notes:   Definitions only
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ==========================================================================
// Clock and bus timing
`define RTC_CLK_MHZ        50
`define RTC_T_RSTL_US      480
`define RTC_T_PDH_US       30
`define RTC_T_PDL_US       120
`define RTC_T_SAMPLE_US    30
`define RTC_CYC(us)        ((us) * `RTC_CLK_MHZ)
`define RTC_OSC_DIV        32768

// ==========================================================================
// Identification code
`define RTC_ROM_BITS       64
`define RTC_ROM_CRC_LSB    56
`define RTC_SERIAL_LSB     8
`define RTC_CRC_POLY       8'h8C

// ==========================================================================
// Command codes
`define RTC_CMD_READ_ROM   8'h33
`define RTC_CMD_MATCH_ROM  8'h55
`define RTC_CMD_SEARCH_ROM 8'hF0
`define RTC_CMD_SKIP_ROM   8'hCC
`define RTC_CMD_READ_CLK   8'h66
`define RTC_CMD_WRITE_CLK  8'h99

// ==========================================================================
// Control byte and clock frame
`define RTC_CTRL_OSC_HI    3
`define RTC_CTRL_USER_LSB  4
`define RTC_CTRL_BITS      8
`define RTC_FRAME_BITS     40
`define RTC_CMD_LAST_BIT   7

`endif

// ---- rtc_pkg.sv ----
// Purpose: Types shared by the seconds clock files
// Assumes: Nothing beyond the map header
// Notes:   One-hot protocol states
`default_nettype none

package rtc_pkg;

  // ========================================================================
  // Protocol states
  typedef enum logic [10:0] {
    st_idle   = 11'h001,
    st_pdh    = 11'h002,
    st_pdl    = 11'h004,
    st_romcmd = 11'h008,
    st_romrd  = 11'h010,
    st_match  = 11'h020,
    st_search = 11'h040,
    st_fncmd  = 11'h080,
    st_rdclk  = 11'h100,
    st_wrclk  = 11'h200,
    st_halt   = 11'h400
  } ow_state_t;

  typedef logic [63:0] rom_code_t;

endpackage : rtc_pkg

`default_nettype wire

// ---- rom_code_gen.sv ----
// Purpose: Builds the 64-bit identification code with its check byte
// Assumes: Family and serial are fixed by parameters
// Notes:   Purely combinational; folds away to constants
`default_nettype none
`include "rtc_map.svh"

module rom_code_gen #(
  parameter logic [7:0]  FAMILY = 8'h5A,            // Arbitrary value
  parameter logic [47:0] SERIAL = 48'h0123456789AB  // Arbitrary value
) (
  output var rtc_pkg::rom_code_t rom_code
);
  import rtc_pkg::*;

  logic [55:0] body;
  logic [7:0]  crc;
  logic        fb;

  // ========================================================================
  // Serial check over the first 56 bits, family first, LSB first
  always_comb begin
    body = {SERIAL, FAMILY};                                   // RULE1
    crc  = 8'h00;                                              // RULE3
    fb   = 1'b0;
    for (int i = 0; i < `RTC_ROM_CRC_LSB; i++) begin
      fb  = crc[0] ^ body[i];                                  // RULE3
      crc = {1'b0, crc[7:1]};
      if (fb) begin
        crc = crc ^ `RTC_CRC_POLY;                             // RULE2
      end
    end
    rom_code = {crc, body};                                    // RULE1
  end

endmodule : rom_code_gen

`default_nettype wire

// ---- second_tick.sv ----
// Purpose: One-second tick from the 32.768 kHz oscillator pin
// Assumes: Oscillator far slower than clk_sys
// Notes:   Prescaler holds while stopped, so no partial second is lost
`default_nettype none
`include "rtc_map.svh"

module second_tick #(
  parameter int unsigned DIV = `RTC_OSC_DIV
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic osc_pin,
  input  wire logic run,
  output logic      tick
);

  logic        osc_m_ff, osc_s_ff, osc_d_ff;
  logic [15:0] div_ff,   nxt_div;
  logic        tick_ff,  nxt_tick;

  // ========================================================================
  // Prescaler
  always_comb begin
    nxt_div  = div_ff;
    nxt_tick = 1'b0;
    if (run && osc_s_ff && !osc_d_ff) begin                    // RULE6
      if (div_ff == 16'(DIV - 1)) begin
        nxt_div  = 16'h0000;
        nxt_tick = 1'b1;
      end else begin
        nxt_div = div_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      osc_m_ff <= 1'b0;
      osc_s_ff <= 1'b0;
      osc_d_ff <= 1'b0;
      div_ff   <= 16'h0000;
      tick_ff  <= 1'b0;
    end else begin
      osc_m_ff <= osc_pin;
      osc_s_ff <= osc_m_ff;
      osc_d_ff <= osc_s_ff;
      div_ff   <= nxt_div;
      tick_ff  <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : second_tick

`default_nettype wire

// ---- serial_bus_seconds_counter_rtc.sv ----
// Purpose: Slave end of a single-wire seconds counter clock
// Assumes: Master keeps slot and reset timing; one clock, sync reset
// Notes:   Line is open drain; this block only ever pulls low
//
// Functional notes
// RULE1 - Holds 64-bit code: family byte, 48-bit serial, check byte.
// RULE2 - Check byte is CRC of first 56 bits, x^8+x^5+x^4+1.
// RULE3 - CRC starts at zero, family LSB first; check bits return zero.
// RULE4 - Every byte and field moves least significant bit first.
// RULE5 - Clock commands only after a completed ROM selection command.
// RULE6 - Seconds advance only while software-enabled oscillator runs.
// RULE7 - Reads come from a buffered snapshot, stable during transfer.
// RULE8 - Control bits 0 and 1 always read zero.
// RULE9 - Control bits 3 and 2 both read oscillator running state.
// RULE10 - On control write, bit 3 decides oscillator state.
// RULE11 - Control bits 7 to 4 are plain user storage bits.
// RULE12 - 32-bit counter increments each second and wraps to zero.
// RULE13 - Transfers start at control byte, then counter bytes low to high.
// RULE14 - Read clock 66h snapshots counter after last command bit.
// RULE15 - Reading past five bytes repeats them without new snapshot.
// RULE16 - Reset pulse aborts a read at any bit; device stops sending.
// RULE17 - Write clock 99h: control byte first, applied on receipt.
// RULE18 - Written time bytes reach counter at the next reset pulse.
// RULE19 - Stopped oscillator keeps counter value unchanged.
// RULE20 - Device is always a slave and never starts a transaction.
// RULE21 - Every slot starts at master falling edge; device aligns to it.
// RULE22 - ROM commands 33h read, 55h match, F0h search, CCh skip.
// RULE23 - Reset low at least 480 us; presence after 15-60 us, 60-240 us.
// RULE24 - Write slots sampled after delay; read 0 held low for delay.
// RULE25 - Other function codes ignored until next reset pulse.
`default_nettype none
`include "rtc_map.svh"

module serial_bus_seconds_counter_rtc #(
  parameter int unsigned RST_LOW_CYC = `RTC_CYC(`RTC_T_RSTL_US),
  parameter int unsigned PDH_CYC     = `RTC_CYC(`RTC_T_PDH_US),
  parameter int unsigned PDL_CYC     = `RTC_CYC(`RTC_T_PDL_US),
  parameter int unsigned SAMPLE_CYC  = `RTC_CYC(`RTC_T_SAMPLE_US),
  parameter int unsigned OSC_DIV     = `RTC_OSC_DIV,
  parameter logic [7:0]  FAMILY      = 8'h5A,            // Arbitrary value
  parameter logic [47:0] SERIAL      = 48'h0123456789AB  // Arbitrary value
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic osc_pin,
  input  wire logic owire_in,
  output logic      owire_out,
  output logic      owire_oe_n
);
  import rtc_pkg::*;

  // ========================================================================
  // Declarations
  rom_code_t   rom_code;
  logic        tick;
  logic        line_m_ff, line_s_ff, line_d_ff;
  logic        fall, rise, rx;
  ow_state_t   st_ff,      nxt_st;
  logic [15:0] low_cnt_ff, nxt_low_cnt;
  logic [15:0] tcnt_ff,    nxt_tcnt;
  logic        slot_ff,    nxt_slot;
  logic        drv_n_ff,   nxt_drv_n;
  logic [6:0]  bitn_ff,    nxt_bitn;
  logic [1:0]  phase_ff,   nxt_phase;
  logic [7:0]  sh_ff,      nxt_sh;
  logic        osc_en_ff,  nxt_osc_en;
  logic [3:0]  user_ff,    nxt_user;
  logic [31:0] buf_ff,     nxt_buf;
  logic [31:0] rtc_ff,     nxt_rtc;
  logic        pend_ff,    nxt_pend;
  logic [7:0]  sh_new;
  logic [7:0]  ctrl_rd;
  logic [39:0] frame;
  logic        rom_bit;
  logic        tx_en, tx_bit, active, bit_done;
  logic [4:0]  wr_idx;

  // ========================================================================
  // Submodules
  rom_code_gen #(
    .FAMILY (FAMILY),
    .SERIAL (SERIAL)
  ) u_rom (
    .rom_code (rom_code)
  );

  second_tick #(
    .DIV (OSC_DIV)
  ) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .osc_pin (osc_pin),
    .run     (osc_en_ff),                                      // RULE6
    .tick    (tick)
  );

  // ========================================================================
  // Line synchroniser and edges
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      line_m_ff <= 1'b1;
      line_s_ff <= 1'b1;
      line_d_ff <= 1'b1;
    end else begin
      line_m_ff <= owire_in;
      line_s_ff <= line_m_ff;
      line_d_ff <= line_s_ff;
    end
  end

  assign fall = line_d_ff && !line_s_ff;                       // RULE21
  assign rise = !line_d_ff && line_s_ff;
  assign rx   = line_s_ff;

  // ========================================================================
  // Read views
  assign ctrl_rd = {user_ff, osc_en_ff, osc_en_ff, 2'b00};     // RULE8 RULE9 RULE11
  assign frame   = {buf_ff, ctrl_rd};                          // RULE7 RULE13
  assign rom_bit = rom_code[bitn_ff[5:0]];                     // RULE4
  assign sh_new  = {rx, sh_ff[7:1]};                           // RULE4
  assign wr_idx  = 5'(bitn_ff - 7'(`RTC_CTRL_BITS));

  // Bit to send in a read slot; phase 1 of search sends the complement
  always_comb begin
    tx_en  = 1'b0;
    tx_bit = 1'b1;
    case (st_ff)
      st_romrd: begin
        tx_en  = 1'b1;
        tx_bit = rom_bit;
      end
      st_search: begin
        tx_en  = (phase_ff != 2'd2);
        tx_bit = (phase_ff == 2'd1) ? !rom_bit : rom_bit;
      end
      st_rdclk: begin
        tx_en  = 1'b1;
        tx_bit = frame[bitn_ff[5:0]];                          // RULE13
      end
      default: begin
        tx_en  = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  assign active = (st_ff != st_idle) && (st_ff != st_pdh) &&
                  (st_ff != st_pdl) && (st_ff != st_halt);

  // ========================================================================
  // Protocol and timekeeping
  always_comb begin
    nxt_st      = st_ff;
    nxt_low_cnt = low_cnt_ff;
    nxt_tcnt    = tcnt_ff;
    nxt_slot    = slot_ff;
    nxt_drv_n   = drv_n_ff;
    nxt_bitn    = bitn_ff;
    nxt_phase   = phase_ff;
    nxt_sh      = sh_ff;
    nxt_osc_en  = osc_en_ff;
    nxt_user    = user_ff;
    nxt_buf     = buf_ff;
    nxt_rtc     = rtc_ff;
    nxt_pend    = pend_ff;
    bit_done    = 1'b0;

    // Counter stands still while the oscillator is off
    if (tick && osc_en_ff) begin                               // RULE19
      nxt_rtc = rtc_ff + 32'h0000_0001;                        // RULE12
    end

    // Low time on the wire, saturating
    if (!line_s_ff) begin
      if (low_cnt_ff != 16'hFFFF) begin
        nxt_low_cnt = low_cnt_ff + 16'h0001;
      end
    end else begin
      nxt_low_cnt = 16'h0000;
    end

    // Presence and slot timing; never starts a slot on its own
    if (st_ff == st_pdh) begin
      if (tcnt_ff == 16'(PDH_CYC - 1)) begin                   // RULE23
        nxt_st    = st_pdl;
        nxt_tcnt  = 16'h0000;
        nxt_drv_n = 1'b0;
      end else begin
        nxt_tcnt = tcnt_ff + 16'h0001;
      end
    end else if (st_ff == st_pdl) begin
      if (tcnt_ff == 16'(PDL_CYC - 1)) begin                   // RULE23
        nxt_st    = st_romcmd;
        nxt_drv_n = 1'b1;
        nxt_bitn  = 7'd0;
      end else begin
        nxt_tcnt = tcnt_ff + 16'h0001;
      end
    end else if (active) begin
      if (!slot_ff) begin
        if (fall) begin                                        // RULE20 RULE21
          nxt_slot  = 1'b1;
          nxt_tcnt  = 16'h0000;
          nxt_drv_n = !(tx_en && !tx_bit);                     // RULE24
        end
      end else if (tcnt_ff == 16'(SAMPLE_CYC - 1)) begin       // RULE24
        nxt_slot  = 1'b0;
        nxt_drv_n = 1'b1;
        bit_done  = 1'b1;
      end else begin
        nxt_tcnt = tcnt_ff + 16'h0001;
      end
    end

    // Per-bit actions at the end of each slot
    if (bit_done) begin
      case (st_ff)
        st_romcmd: begin
          nxt_sh   = sh_new;
          nxt_bitn = bitn_ff + 7'd1;
          if (bitn_ff == 7'(`RTC_CMD_LAST_BIT)) begin
            nxt_bitn  = 7'd0;
            nxt_phase = 2'd0;
            case (sh_new)                                      // RULE22
              `RTC_CMD_READ_ROM:   nxt_st = st_romrd;
              `RTC_CMD_MATCH_ROM:  nxt_st = st_match;
              `RTC_CMD_SEARCH_ROM: nxt_st = st_search;
              `RTC_CMD_SKIP_ROM:   nxt_st = st_fncmd;          // RULE5
              default:             nxt_st = st_halt;
            endcase
          end
        end
        st_romrd, st_match: begin
          if (st_ff == st_match && rx != rom_bit) begin
            nxt_st = st_halt;
          end else if (bitn_ff == 7'(`RTC_ROM_BITS - 1)) begin
            nxt_st   = st_fncmd;                               // RULE5
            nxt_bitn = 7'd0;
          end else begin
            nxt_bitn = bitn_ff + 7'd1;
          end
        end
        st_search: begin
          if (phase_ff != 2'd2) begin
            nxt_phase = phase_ff + 2'd1;
          end else if (rx != rom_bit) begin
            nxt_st = st_halt;
          end else if (bitn_ff == 7'(`RTC_ROM_BITS - 1)) begin
            nxt_st   = st_fncmd;                               // RULE5
            nxt_bitn = 7'd0;
          end else begin
            nxt_phase = 2'd0;
            nxt_bitn  = bitn_ff + 7'd1;
          end
        end
        st_fncmd: begin
          nxt_sh   = sh_new;
          nxt_bitn = bitn_ff + 7'd1;
          if (bitn_ff == 7'(`RTC_CMD_LAST_BIT)) begin
            nxt_bitn = 7'd0;
            if (sh_new == `RTC_CMD_READ_CLK) begin
              nxt_st  = st_rdclk;
              nxt_buf = rtc_ff;                                // RULE7 RULE14
            end else if (sh_new == `RTC_CMD_WRITE_CLK) begin
              nxt_st = st_wrclk;
            end else begin
              nxt_st = st_halt;                                // RULE25
            end
          end
        end
        st_rdclk: begin
          if (bitn_ff == 7'(`RTC_FRAME_BITS - 1)) begin
            nxt_bitn = 7'd0;                                   // RULE15
          end else begin
            nxt_bitn = bitn_ff + 7'd1;
          end
        end
        st_wrclk: begin
          // Bits past the fifth byte are dropped
          if (bitn_ff < 7'(`RTC_CTRL_BITS)) begin
            nxt_sh   = sh_new;
            nxt_bitn = bitn_ff + 7'd1;
            if (bitn_ff == 7'(`RTC_CTRL_BITS - 1)) begin       // RULE17
              nxt_osc_en = sh_new[`RTC_CTRL_OSC_HI];           // RULE10
              nxt_user   = sh_new[7:`RTC_CTRL_USER_LSB];       // RULE11
            end
          end else if (bitn_ff < 7'(`RTC_FRAME_BITS)) begin
            nxt_buf[wr_idx] = rx;                              // RULE13
            nxt_bitn        = bitn_ff + 7'd1;
            if (bitn_ff == 7'(`RTC_FRAME_BITS - 1)) begin
              nxt_pend = 1'b1;
            end
          end
        end
        default: begin
          nxt_st = st_ff;
        end
      endcase
    end

    // Reset pulse ends any transaction at any bit
    if (rise && low_cnt_ff >= 16'(RST_LOW_CYC)) begin          // RULE16 RULE23
      nxt_st    = st_pdh;
      nxt_tcnt  = 16'h0000;
      nxt_slot  = 1'b0;
      nxt_drv_n = 1'b1;
      nxt_bitn  = 7'd0;
      nxt_phase = 2'd0;
      if (pend_ff) begin
        nxt_rtc  = buf_ff;                                     // RULE18
        nxt_pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_ff      <= st_idle;
      low_cnt_ff <= 16'h0000;
      tcnt_ff    <= 16'h0000;
      slot_ff    <= 1'b0;
      drv_n_ff   <= 1'b1;
      bitn_ff    <= 7'd0;
      phase_ff   <= 2'd0;
      sh_ff      <= 8'h00;
      osc_en_ff  <= 1'b0;
      user_ff    <= 4'h0;
      buf_ff     <= 32'h0000_0000;
      rtc_ff     <= 32'h0000_0000;
      pend_ff    <= 1'b0;
      owire_out  <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      low_cnt_ff <= nxt_low_cnt;
      tcnt_ff    <= nxt_tcnt;
      slot_ff    <= nxt_slot;
      drv_n_ff   <= nxt_drv_n;
      bitn_ff    <= nxt_bitn;
      phase_ff   <= nxt_phase;
      sh_ff      <= nxt_sh;
      osc_en_ff  <= nxt_osc_en;
      user_ff    <= nxt_user;
      buf_ff     <= nxt_buf;
      rtc_ff     <= nxt_rtc;
      pend_ff    <= nxt_pend;
      owire_out  <= 1'b0;
    end
  end

  // Open drain: only ever pulls low
  assign owire_oe_n = drv_n_ff;

endmodule : serial_bus_seconds_counter_rtc

`default_nettype wire

// ---- rtc_checker_props.sv ----
// Purpose: Wire-level checks for the seconds clock slave
// Assumes: Sees only the top module ports
// Notes:   Run counters saturate, so long idle spans stay harmless
`default_nettype none

module rtc_checker #(
  parameter int unsigned RST_LOW_CYC = 2000,
  parameter int unsigned PDH_CYC     = 1500,
  parameter int unsigned PDL_CYC     = 50,
  parameter int unsigned SAMPLE_CYC  = 1500
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic owire_in,
  input wire logic owire_out,
  input wire logic owire_oe_n
);
  // ==========================================================================
  // Run lengths of wire low, our pull-down, time since wire edges
  logic        in_d_ff;
  logic        nxt_in_d;
  logic [15:0] low_ff, drv_ff, fall_ff, rise_ff, pres_ff;
  logic [15:0] nxt_low, nxt_drv, nxt_fall, nxt_rise, nxt_pres;

  always_comb begin
    nxt_in_d = owire_in;
    nxt_low  = owire_in ? 16'h0000 : low_ff + {15'h0000, ~&low_ff};
    nxt_drv  = owire_oe_n ? 16'h0000 : drv_ff + {15'h0000, ~&drv_ff};
    nxt_fall = (!owire_in && in_d_ff) ? 16'h0000 : fall_ff + {15'h0000, ~&fall_ff};
    nxt_rise = (owire_in && !in_d_ff) ? 16'h0000 : rise_ff + {15'h0000, ~&rise_ff};
    // Cycles since the end of the last reset pulse
    nxt_pres = (owire_in && !in_d_ff && low_ff >= RST_LOW_CYC + 4) ? 16'h0000 :
               pres_ff + {15'h0000, ~&pres_ff};
    if (!rstn) begin
      nxt_in_d = 1'b1;
      nxt_low  = 16'h0000;
      nxt_drv  = 16'h0000;
      nxt_fall = 16'hFFFF;
      nxt_rise = 16'hFFFF;
      nxt_pres = 16'hFFFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    in_d_ff <= nxt_in_d;
    low_ff  <= nxt_low;
    drv_ff  <= nxt_drv;
    fall_ff <= nxt_fall;
    rise_ff <= nxt_rise;
    pres_ff <= nxt_pres;
  end

  // ==========================================================================
  // Wire behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_OUT_ZERO: assert property (owire_out == 1'b0)
    else $error("data output not low");
  AST_RST_RELEASED: assert property (disable iff (1'b0) !rstn |=> owire_oe_n)
    else $error("wire pulled during reset");
  AST_PRES_DELAY: assert property (
    pres_ff == 16'(PDH_CYC + 2) |-> $fell(owire_oe_n))
    else $error("presence pulse late or missing");
  AST_PRES_QUIET: assert property (
    $rose(owire_in) && low_ff >= RST_LOW_CYC + 4 |-> owire_oe_n [*8])
    else $error("presence pulse too early");
  AST_DRIVE_WIDTH: assert property (
    $rose(owire_oe_n) |-> drv_ff == 16'(PDL_CYC) ||
    (drv_ff >= 16'(SAMPLE_CYC - 1) && drv_ff <= 16'(SAMPLE_CYC + 1)))
    else $error("pull-down width wrong");
  AST_DRIVE_CAUSE: assert property (
    $fell(owire_oe_n) |-> (fall_ff >= 16'h0002 && fall_ff <= 16'h0008) ||
    (rise_ff >= 16'(PDH_CYC) && rise_ff <= 16'(PDH_CYC + 8)))
    else $error("pull-down without master edge");
  AST_QUIET_IN_RESET: assert property (
    low_ff >= 16'(SAMPLE_CYC + PDL_CYC) |-> owire_oe_n)
    else $error("pull-down during reset pulse");
  AST_SLOT_SINGLE: assert property ($rose(owire_oe_n) |=> owire_oe_n [*8])
    else $error("pull-down restarted inside slot");
endmodule : rtc_checker

bind serial_bus_seconds_counter_rtc rtc_checker #(
  .RST_LOW_CYC(RST_LOW_CYC),
  .PDH_CYC    (PDH_CYC),
  .PDL_CYC    (PDL_CYC),
  .SAMPLE_CYC (SAMPLE_CYC)
) u_rtc_checker (
  .clk_sys   (clk_sys),
  .rstn      (rstn),
  .owire_in  (owire_in),
  .owire_out (owire_out),
  .owire_oe_n(owire_oe_n)
);

`default_nettype wire

// ---- bus_master_model.sv ----
// Purpose: Bus master driving the open-drain wire
// Assumes: Pull-up on the wire; slave slots last SMP_CYC cycles
// Notes:   Write slots are kept short, SMP_CYC plus a small margin; read slots run about 1.5 SMP_CYC
`default_nettype none

module bus_master_model #(
  parameter int unsigned RST_CYC  = 2100,
  parameter int unsigned SMP_CYC  = 1500,
  parameter int unsigned PRES_CYC = 1700
) (
  input  wire logic clk_sys,
  input  wire logic owire_oe_n,
  output wire logic owire_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic master_low = 1'b0;

  // Pull-up wins unless a party pulls low
  assign owire_in = !master_low && (owire_oe_n !== 1'b0);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic bus_reset(output logic seen);
    seen = 1'b0;
    cyc(1);
    master_low = 1'b1;
    cyc(RST_CYC);
    master_low = 1'b0;
    repeat (PRES_CYC) begin
      cyc(1);
      if (!owire_in) seen = 1'b1;
    end
  endtask : bus_reset

  task automatic write_bit(input logic b);
    cyc(1);
    master_low = 1'b1;
    cyc(b ? 5 : SMP_CYC + 15);
    master_low = 1'b0;
    cyc(b ? SMP_CYC + 15 : 10);
  endtask : write_bit

  task automatic read_bit(output logic b);
    cyc(1);
    master_low = 1'b1;
    cyc(2);
    master_low = 1'b0;
    cyc(SMP_CYC / 2 - 2);
    b = owire_in;
    cyc(SMP_CYC);
  endtask : read_bit

  task automatic write_bits(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) write_bit(v[i]);
  endtask : write_bits

  task automatic read_bits(output logic [63:0] v, input int n);
    logic b;
    v = 64'h0;
    for (int i = 0; i < n; i++) begin
      read_bit(b);
      v[i] = b;
    end
  endtask : read_bits
endmodule : bus_master_model

`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the seconds clock slave
// Assumes: Shortened reset, presence and slot counts, divide-by-4 oscillator
// Notes:   Short slots keep the whole run near 40k clock cycles
`default_nettype none
`include "rtc_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0]  FAM = 8'hC3;            // Arbitrary value
  localparam logic [47:0] SER = 48'hA1B2C3D4E5F6; // Arbitrary value

  logic        clk_sys;
  logic        rstn;
  logic        osc_pin;
  wire logic   owire_in;
  logic        owire_out;
  logic        owire_oe_n;
  logic [63:0] v;
  logic [63:0] rom_exp;
  int          errors;
  int          cmp_count;

  serial_bus_seconds_counter_rtc #(
    .RST_LOW_CYC(200),
    .PDH_CYC    (40),
    .PDL_CYC    (50),
    .SAMPLE_CYC (60),
    .OSC_DIV    (4),
    .FAMILY     (FAM),
    .SERIAL     (SER)
  ) dut (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .osc_pin   (osc_pin),
    .owire_in  (owire_in),
    .owire_out (owire_out),
    .owire_oe_n(owire_oe_n)
  );

  bus_master_model #(
    .RST_CYC (250),
    .SMP_CYC (60),
    .PRES_CYC(200)
  ) u_master (
    .clk_sys   (clk_sys),
    .owire_oe_n(owire_oe_n),
    .owire_in  (owire_in)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction : crc8

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic start(input logic [7:0] rom_cmd);
    logic seen;
    u_master.bus_reset(seen);
    chk({63'h0, seen}, 64'h1);
    u_master.write_bits({56'h0, rom_cmd}, 8);
  endtask : start

  // Held still between bursts, so tick counts stay exact
  task automatic osc_pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_sys);
      #1 osc_pin = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1 osc_pin = 1'b0;
    end
  endtask : osc_pulses

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Tests
  initial begin
    rstn = 1'b0;
    osc_pin = 1'b0;
    errors = 0;
    cmp_count = 0;
    rom_exp = {crc8({8'h00, SER, FAM}, 56), SER, FAM};
    repeat (5) @(posedge clk_sys);
    #1 rstn = 1'b1;
    // Oscillator off, all-ones time, read past the frame
    start(`RTC_CMD_SKIP_ROM);
    u_master.write_bits({56'h0, `RTC_CMD_WRITE_CLK}, 8);
    u_master.write_bits({24'h0, 32'hFFFFFFFF, 8'hA7}, 40);
    start(`RTC_CMD_SKIP_ROM);
    osc_pulses(8);
    u_master.write_bits({56'h0, `RTC_CMD_READ_CLK}, 8);
    u_master.read_bits(v, 48);
    chk(v, {16'h0, 8'hA0, 32'hFFFFFFFF, 8'hA0});
    $display("test 1 done");
    // Control alone starts oscillator at once; one second wraps
    start(`RTC_CMD_SKIP_ROM);
    u_master.write_bits({56'h0, `RTC_CMD_WRITE_CLK}, 8);
    u_master.write_bits({56'h0, 8'h5B}, 8);
    osc_pulses(4);
    start(`RTC_CMD_READ_ROM);
    u_master.read_bits(v, 64);
    chk(v, rom_exp);
    chk({56'h0, crc8(v, 64)}, 64'h0);
    u_master.write_bits({56'h0, `RTC_CMD_READ_CLK}, 8);
    fork
      osc_pulses(12);
      u_master.read_bits(v, 44);
    join
    chk(v, {20'h0, 4'hC, 32'h0, 8'h5C});
    $display("test 2 done");
    // Clock command without selection, then unknown function code after match
    start(`RTC_CMD_READ_CLK);
    u_master.read_bits(v, 8);
    chk(v, 64'hFF);
    start(`RTC_CMD_MATCH_ROM);
    u_master.write_bits(rom_exp, 64);
    u_master.write_bits({56'h0, 8'h0F}, 8);
    u_master.read_bits(v, 8);
    chk(v, 64'hFF);
    $display("test 3 done");
    // Search walks eight bits, then a wrong bit drops the device out
    start(`RTC_CMD_SEARCH_ROM);
    for (int i = 0; i < 9; i++) begin
      u_master.read_bits(v, 2);
      if (i < 8) chk(v, {62'h0, !rom_exp[i], rom_exp[i]});
      u_master.write_bits({63'h0, rom_exp[i] ^ (i == 8)}, 1);
    end
    u_master.read_bits(v, 8);
    chk(v, 64'hFF);
    $display("test 4 done");
    print_verdict();
  end

  initial begin
    #1_600_000;
    errors++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
